// ---- fcs_pkg.sv ----
// constants and types for the flash command and status engine
// assumes one 10 MHz system clock shared with the cpu bus
package fcs_pkg;
	localparam int TMR_W = 16;
	localparam int CLK_PERIOD_NS = 100;
	localparam int CMD_GAP_NS = 80_000;
	localparam int WINDOW_NS = 80_000;
	localparam int PROT_NS = 100_000;
	localparam logic [TMR_W-1:0] CMD_GAP_CYC = TMR_W'(CMD_GAP_NS / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] WINDOW_CYC = TMR_W'(WINDOW_NS / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] PROT_CYC_DEF = TMR_W'(PROT_NS / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] PROG_CYC_DEF = 16'h0014;
	localparam logic [TMR_W-1:0] ERASE_CYC_DEF = 16'h07D0;
	localparam logic [11:0] ADDR_UNLOCK1 = 12'h555;
	localparam logic [11:0] ADDR_UNLOCK2 = 12'hAAA;
	localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
	localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
	localparam logic [7:0] CMD_PROGRAM = 8'hA0;
	localparam logic [7:0] CMD_BYPASS = 8'h20;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CMD_BULK = 8'h10;
	localparam logic [7:0] CMD_SECTOR = 8'h30;
	localparam logic [7:0] CMD_RESET = 8'hF0;
	localparam logic [7:0] CMD_BYP_EXIT1 = 8'h90;
	localparam logic [7:0] CMD_BYP_EXIT2 = 8'h00;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [7:0] RDATA_RESET = 8'h00;
	localparam int POLL_BIT = 7;
	localparam int TOGGLE_BIT = 6;
	localparam int ERROR_BIT = 5;
	localparam int WINDOW_BIT = 3;
	typedef enum logic [3:0] {
		S_READ, S_UNLK1, S_UNLK2, S_PROG_DATA, S_ERS_SETUP, S_ERS_U1, S_ERS_U2,
		S_ERS_WINDOW, S_PROGRAM, S_ERASE, S_PROT, S_FAIL, S_BYP, S_BYP_PROG, S_BYP_EXIT
	} fcs_state_type;
endpackage

// ---- fcs_timer_if.sv ----
// carrier between the engine and one of its down-counters
// assumes start is a one-cycle request in the sys_clk domain
`timescale 1ns/1ps
interface fcs_timer_if #(parameter int W = 16);
	logic start;
	logic [W-1:0] load;
	logic busy;
	logic done;
	modport timer(input start, input load, output busy, output done);
	modport user(output start, output load, input busy, input done);
endinterface

// ---- fcs_timer.sv ----
// down-counter: loads on start, pulses done on the last count
// assumes load is at least one
`timescale 1ns/1ps
module fcs_timer #(
	parameter int W = 16
) (
	input wire logic sys_clk,
	input wire logic rst,
	fcs_timer_if.timer t
);
	logic [W-1:0] count;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			count <= '0;
		end else if (t.start) begin
			count <= t.load;
		end else if (count != '0) begin
			count <= count - 1'b1;
		end
	end

	// a restart in the last cycle suppresses done, so an append is never lost
	assign t.busy = (count != '0);
	assign t.done = (count == W'(1)) && !t.start;

	timer_done_a: assert property (@(posedge sys_clk) disable iff (rst)
		$fell(t.busy) |-> $past(t.done)) else $error("timer stopped without done");
endmodule

// ---- fcs_engine.sv ----
// flash command decoder, sector array and status flag engine
// assumes the cpu bus runs on sys_clk; reads answer one cycle later
`timescale 1ns/1ps
module fcs_engine import fcs_pkg::*; #(
	parameter int SECTORS = 4,
	parameter int SECT_AW = 4,
	parameter logic [TMR_W-1:0] PROT_CYC = PROT_CYC_DEF,
	parameter logic [TMR_W-1:0] PROG_CYC = PROG_CYC_DEF,
	parameter logic [TMR_W-1:0] ERASE_CYC = ERASE_CYC_DEF
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [15:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [SECTORS-1:0] main_sector_select,
	input wire logic [SECTORS-1:0] sector_protect,
	input wire logic cell_fault,
	output logic [7:0] bus_rdata,
	output logic ready_busy_pin,
	output logic error_flag
);
	localparam int SEL_W = $clog2(SECTORS);
	localparam int IDX_W = SEL_W + SECT_AW;
	localparam int DEPTH = SECTORS << SECT_AW;

	fcs_state_type state;
	logic bypass;
	logic was_prog;
	logic toggle_flag;
	logic [7:0] prog_data;
	logic [IDX_W-1:0] prog_idx;
	logic [SECTORS-1:0] erase_mask;
	logic [7:0] mem [DEPTH];

	logic sel_any;
	logic [SEL_W-1:0] sel_idx;
	logic [IDX_W-1:0] byte_idx;
	logic [11:0] low_addr;
	logic wr_acc;
	logic rd_acc;
	logic is_unlk1;
	logic is_unlk2;
	logic at_cmd;
	logic is_reset;
	logic prog_go;
	logic bulk_go;
	logic sect_add;
	logic win_end;
	logic [SECTORS-1:0] erase_target;
	logic erase_go;
	logic prot_go;
	logic prog_bad;
	logic op_fail;
	logic status_mode;
	logic busy;
	logic [7:0] status_byte;

	fcs_timer_if #(.W(TMR_W)) cmd_t();
	fcs_timer_if #(.W(TMR_W)) win_t();
	fcs_timer_if #(.W(TMR_W)) op_t();
	fcs_timer_if #(.W(TMR_W)) prot_t();

	fcs_timer #(.W(TMR_W)) u_cmd_timer (.sys_clk(sys_clk), .rst(rst), .t(cmd_t));
	fcs_timer #(.W(TMR_W)) u_win_timer (.sys_clk(sys_clk), .rst(rst), .t(win_t));
	fcs_timer #(.W(TMR_W)) u_op_timer (.sys_clk(sys_clk), .rst(rst), .t(op_t));
	fcs_timer #(.W(TMR_W)) u_prot_timer (.sys_clk(sys_clk), .rst(rst), .t(prot_t));

	always_comb begin
		sel_idx = '0;
		for (int i = 0; i < SECTORS; i++) begin
			if (main_sector_select[i]) begin
				sel_idx = SEL_W'(i);
			end
		end
	end

	// nothing happens on the bus unless a sector of this array is selected
	assign sel_any = |main_sector_select;
	assign wr_acc = bus_wr && sel_any;
	assign rd_acc = bus_rd && sel_any;
	assign low_addr = bus_addr[11:0];
	assign byte_idx = {sel_idx, bus_addr[SECT_AW-1:0]};
	assign is_unlk1 = (low_addr == ADDR_UNLOCK1) && (bus_wdata == CMD_UNLOCK1);
	assign is_unlk2 = (low_addr == ADDR_UNLOCK2) && (bus_wdata == CMD_UNLOCK2);
	assign at_cmd = (low_addr == ADDR_UNLOCK1);
	assign is_reset = wr_acc && (bus_wdata == CMD_RESET);

	assign prog_go = wr_acc && (state == S_PROG_DATA || state == S_BYP_PROG)
		&& !sector_protect[sel_idx];
	assign bulk_go = wr_acc && (state == S_ERS_U2) && at_cmd && (bus_wdata == CMD_BULK);
	assign sect_add = wr_acc && (bus_wdata == CMD_SECTOR)
		&& (state == S_ERS_U2 || state == S_ERS_WINDOW);
	assign win_end = (state == S_ERS_WINDOW) && win_t.done;
	// a bulk erase covers every unprotected sector whichever one took the command
	assign erase_target = (bulk_go ? '1 : erase_mask) & ~sector_protect;
	assign erase_go = (bulk_go || win_end) && (|erase_target);
	assign prot_go = (bulk_go || win_end) && !(|erase_target);

	// trying to raise a programmed bit, or a bad cell, fails the operation
	assign prog_bad = |(prog_data & ~mem[prog_idx]) || cell_fault;
	assign op_fail = op_t.done && ((state == S_PROGRAM) ? prog_bad : cell_fault);

	// every accepted write restarts the gap timer, so done means a stall
	assign cmd_t.start = wr_acc;
	assign cmd_t.load = CMD_GAP_CYC;
	assign win_t.start = sect_add;
	assign win_t.load = WINDOW_CYC;
	assign op_t.start = prog_go || erase_go;
	assign op_t.load = prog_go ? PROG_CYC : ERASE_CYC;
	assign prot_t.start = prot_go;
	assign prot_t.load = PROT_CYC;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state <= S_READ;
		end else begin
			case (state)
				S_READ: begin
					if (wr_acc && is_unlk1) begin
						state <= S_UNLK1;
					end
				end
				S_UNLK1: begin
					if (cmd_t.done) begin
						state <= S_READ;
					end else if (wr_acc) begin
						state <= is_unlk2 ? S_UNLK2 : S_READ;
					end
				end
				S_UNLK2: begin
					if (cmd_t.done) begin
						state <= S_READ;
					end else if (wr_acc) begin
						if (at_cmd && bus_wdata == CMD_PROGRAM) begin
							state <= S_PROG_DATA;
						end else if (at_cmd && bus_wdata == CMD_BYPASS) begin
							state <= S_BYP;
						end else if (at_cmd && bus_wdata == CMD_ERASE_SETUP) begin
							state <= S_ERS_SETUP;
						end else begin
							state <= S_READ;
						end
					end
				end
				S_PROG_DATA: begin
					if (cmd_t.done) begin
						state <= S_READ;
					end else if (wr_acc) begin
						state <= prog_go ? S_PROGRAM : S_READ;
					end
				end
				S_ERS_SETUP: begin
					if (cmd_t.done) begin
						state <= S_READ;
					end else if (wr_acc) begin
						state <= is_unlk1 ? S_ERS_U1 : S_READ;
					end
				end
				S_ERS_U1: begin
					if (cmd_t.done) begin
						state <= S_READ;
					end else if (wr_acc) begin
						state <= is_unlk2 ? S_ERS_U2 : S_READ;
					end
				end
				S_ERS_U2: begin
					if (cmd_t.done) begin
						state <= S_READ;
					end else if (erase_go) begin
						state <= S_ERASE;
					end else if (prot_go) begin
						state <= S_PROT;
					end else if (sect_add) begin
						state <= S_ERS_WINDOW;
					end else if (wr_acc) begin
						state <= S_READ;
					end
				end
				S_ERS_WINDOW: begin
					if (erase_go) begin
						state <= S_ERASE;
					end else if (prot_go) begin
						state <= S_PROT;
					end else if (is_reset) begin
						state <= S_READ;
					end
				end
				S_PROGRAM, S_ERASE: begin
					if (op_fail) begin
						state <= S_FAIL;
					end else if (op_t.done) begin
						state <= bypass ? S_BYP : S_READ;
					end
				end
				S_PROT: begin
					if (prot_t.done) begin
						state <= S_READ;
					end
				end
				S_FAIL: begin
					if (is_reset) begin
						state <= S_READ;
					end
				end
				S_BYP: begin
					if (wr_acc && bus_wdata == CMD_PROGRAM) begin
						state <= S_BYP_PROG;
					end else if (wr_acc && bus_wdata == CMD_BYP_EXIT1) begin
						state <= S_BYP_EXIT;
					end
				end
				S_BYP_PROG: begin
					if (wr_acc) begin
						state <= prog_go ? S_PROGRAM : S_BYP;
					end
				end
				S_BYP_EXIT: begin
					if (wr_acc) begin
						state <= (bus_wdata == CMD_BYP_EXIT2) ? S_READ : S_BYP;
					end
				end
				default: begin
					state <= S_READ;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bypass <= 1'b0;
		end else if (state == S_UNLK2 && wr_acc && at_cmd && bus_wdata == CMD_BYPASS) begin
			bypass <= 1'b1;
		end else if (state == S_BYP_EXIT && wr_acc && bus_wdata == CMD_BYP_EXIT2) begin
			bypass <= 1'b0;
		end else if (state == S_FAIL && is_reset) begin
			bypass <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			prog_idx <= '0;
			prog_data <= ERASED_BYTE;
			was_prog <= 1'b0;
		end else if (prog_go) begin
			prog_idx <= byte_idx;
			prog_data <= bus_wdata;
			was_prog <= 1'b1;
		end else if (erase_go || prot_go || sect_add) begin
			// an older program must not show through the polling bit during an erase
			was_prog <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			erase_mask <= '0;
		end else if (bulk_go) begin
			erase_mask <= '1;
		end else if (sect_add && state == S_ERS_U2) begin
			erase_mask <= main_sector_select;
		end else if (sect_add) begin
			erase_mask <= erase_mask | main_sector_select;
		end
	end

	// cells keep their contents across reset, like the real array
	always_ff @(posedge sys_clk) begin
		if (op_t.done && state == S_PROGRAM && !op_fail) begin
			mem[prog_idx] <= mem[prog_idx] & prog_data;
		end else if (op_t.done && state == S_ERASE && !op_fail) begin
			for (int i = 0; i < DEPTH; i++) begin
				if (erase_mask[i >> SECT_AW] && !sector_protect[i >> SECT_AW]) begin
					mem[i] <= ERASED_BYTE;
				end
			end
		end
	end

	// set wins over the reset command in the same cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			error_flag <= 1'b0;
		end else if (op_fail) begin
			error_flag <= 1'b1;
		end else if (is_reset && state == S_FAIL) begin
			error_flag <= 1'b0;
		end
	end

	assign status_mode = (state == S_PROGRAM) || (state == S_ERASE)
		|| (state == S_ERS_WINDOW) || (state == S_PROT) || (state == S_FAIL);
	assign busy = (state == S_PROGRAM) || (state == S_ERASE)
		|| (state == S_ERS_WINDOW) || (state == S_PROT);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			toggle_flag <= 1'b0;
		end else if (rd_acc && status_mode && state != S_PROT) begin
			toggle_flag <= ~toggle_flag;
		end
	end

	always_comb begin
		status_byte = '0;
		status_byte[POLL_BIT] = was_prog && !prog_data[7];
		status_byte[TOGGLE_BIT] = (state != S_PROT) && toggle_flag;
		status_byte[ERROR_BIT] = error_flag;
		status_byte[WINDOW_BIT] = (state == S_ERASE);
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bus_rdata <= RDATA_RESET;
		end else if (rd_acc) begin
			bus_rdata <= status_mode ? status_byte : mem[byte_idx];
		end
	end

	assign ready_busy_pin = !busy;

	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	sequence seq_reset_write;
		is_reset && !busy && state != S_BYP && state != S_BYP_PROG && state != S_BYP_EXIT
			&& state != S_PROG_DATA;
	endsequence
	sequence seq_two_status_reads;
		rd_acc && state == S_ERASE ##1 !rd_acc [*2] ##1 rd_acc && state == S_ERASE;
	endsequence
	sequence seq_prog_read;
		rd_acc && state == S_PROGRAM;
	endsequence

	reset_cmd_a: assert property (seq_reset_write |=> state == S_READ)
		else $error("reset command did not return to read-array");
	poll_program_a: assert property (seq_prog_read |=> bus_rdata[7] == ~prog_data[7])
		else $error("polling bit not inverted during program");
	poll_erase_a: assert property (rd_acc && state == S_ERASE |=> bus_rdata[7] == 1'b0)
		else $error("polling bit not zero during erase");
	toggle_flip_a: assert property (seq_two_status_reads
		|=> bus_rdata[6] != $past(bus_rdata[6], 3))
		else $error("toggle bit did not change between reads");
	busy_pin_a: assert property (state == S_PROGRAM || state == S_ERASE
		|-> !ready_busy_pin)
		else $error("ready/busy high during operation");
	no_select_a: assert property (bus_wr && !sel_any && state == S_READ
		|=> state == S_READ)
		else $error("write without select changed state");
	error_hold_a: assert property (error_flag && !(is_reset && state == S_FAIL)
		|=> error_flag)
		else $error("error flag dropped without reset command");
	protect_prog_a: assert property (wr_acc && state == S_PROG_DATA && sector_protect[sel_idx]
		|-> !op_t.start ##1 state == S_READ)
		else $error("program to protected sector was not discarded");
	cmd_gap_a: assert property (state == S_UNLK1 && cmd_t.done |=> state == S_READ)
		else $error("command gap time-out ignored");
	window_flag_a: assert property (rd_acc && state == S_ERS_WINDOW
		|=> {bus_rdata[7], bus_rdata[3]} == 2'b00)
		else $error("polling or window bit set while appending allowed");
	prot_status_a: assert property (prot_go |=> state == S_PROT [*3])
		else $error("protected erase interval too short");
endmodule

// ---- fcs_cpu_model.sv ----
// cpu-side bus master model that issues byte writes and reads to the flash engine
// assumes sys_clk is the engine clock; the testbench calls these tasks one at a time
`timescale 1ns/1ps
module fcs_cpu_model (
	input wire logic sys_clk,
	input wire logic [7:0] bus_rdata,
	output logic [15:0] bus_addr,
	output logic [7:0] bus_wdata,
	output logic bus_wr,
	output logic bus_rd,
	output logic [3:0] main_sector_select
);
	int pace = 0;
	initial begin
		bus_addr = 16'h0000;
		bus_wdata = 8'h00;
		bus_wr = 1'h0;
		bus_rd = 1'h0;
		main_sector_select = 4'h0;
	end
	// select is left asserted between accesses so polling never drops the array
	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [3:0] s);
		repeat (pace) @(posedge sys_clk);
		@(posedge sys_clk);
		bus_addr <= a;
		bus_wdata <= d;
		main_sector_select <= s;
		bus_wr <= 1'h1;
		@(posedge sys_clk);
		bus_wr <= 1'h0;
		bus_addr <= ~a;
		bus_wdata <= ~d;
	endtask
	task automatic rd(input logic [15:0] a, input logic [3:0] s, output logic [7:0] d);
		repeat (pace) @(posedge sys_clk);
		@(posedge sys_clk);
		bus_addr <= a;
		main_sector_select <= s;
		bus_rd <= 1'h1;
		@(posedge sys_clk);
		bus_rd <= 1'h0;
		bus_addr <= ~a;
		@(posedge sys_clk);
		#1;
		d = bus_rdata;
	endtask
	// upper address bits carry junk since only the low twelve are decoded
	task automatic unlock(input logic [3:0] s);
		wr(16'h7555, 8'hAA, s);
		wr(16'hBAAA, 8'h55, s);
	endtask
	task automatic prog(input logic [15:0] a, input logic [7:0] d, input logic [3:0] s);
		unlock(s);
		wr(16'h0555, 8'hA0, s);
		wr(a, d, s);
	endtask
	// done once two reads agree on the toggle bit; bounded so a stuck engine shows up
	task automatic poll(input logic [15:0] a, input logic [3:0] s, output logic [7:0] d);
		logic [7:0] p;
		rd(a, s, p);
		for (int i = 0; i < 2000; i++) begin
			rd(a, s, d);
			if (d[6] === p[6])
				break;
			p = d;
		end
	endtask
endmodule

// ---- testbench.sv ----
// self-checking bench for the flash command and status engine
// assumes the cpu model drives the bus; short protect and erase counts are set here
`timescale 1ns/1ps
module testbench;
	import fcs_pkg::*;
	logic sys_clk = 1'h0;
	logic rst = 1'h1;
	logic [3:0] sector_protect = 4'h0;
	logic cell_fault = 1'h0;
	logic [15:0] bus_addr;
	logic [7:0] bus_wdata;
	logic bus_wr;
	logic bus_rd;
	logic [3:0] main_sector_select;
	logic [7:0] bus_rdata;
	logic ready_busy_pin;
	logic error_flag;
	int n_fail = 0;
	int samples_checked = 0;
	always #50 sys_clk = ~sys_clk;
	fcs_engine #(.PROT_CYC(16'h000A), .ERASE_CYC(16'h001E)) i_dut (
		.sys_clk(sys_clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .main_sector_select(main_sector_select),
		.sector_protect(sector_protect), .cell_fault(cell_fault), .bus_rdata(bus_rdata),
		.ready_busy_pin(ready_busy_pin), .error_flag(error_flag));
	fcs_cpu_model i_cpu (
		.sys_clk(sys_clk), .bus_rdata(bus_rdata), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.main_sector_select(main_sector_select));
	task automatic tally_and_finish();
		$display("compares=%0d mismatches=%0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [15:0] a, input logic [3:0] s, input logic [7:0] e);
		logic [7:0] d;
		i_cpu.rd(a, s, d);
		chk(d, e);
	endtask
	task automatic ers6(input logic [3:0] s, input logic [7:0] c, input logic [15:0] a);
		i_cpu.unlock(s);
		i_cpu.wr(16'h0555, 8'h80, s);
		i_cpu.unlock(s);
		i_cpu.wr(a, c, s);
	endtask
	// f[0]: window bit seen set while busy; f[1]: two busy reads with poll and toggle at 0
	task automatic watch(input logic [15:0] a, input logic [3:0] s, output logic [1:0] f);
		logic [7:0] d;
		logic [7:0] p;
		f = 2'h0;
		p = 8'hFF;
		for (int i = 0; i < 1500; i++) begin
			i_cpu.rd(a, s, d);
			if (ready_busy_pin === 1'h1)
				break;
			if (d[3] === 1'h1)
				f[0] = 1'h1;
			if (d[7:6] === 2'h0 && p[7:6] === 2'h0)
				f[1] = 1'h1;
			p = d;
		end
	endtask
	task automatic t_reset();
		chk({7'h00, ready_busy_pin}, 8'h01);
		chk({7'h00, error_flag}, 8'h00);
		chk(bus_rdata, 8'h00);
	endtask
	task automatic t_erase();
		logic [7:0] d;
		logic [7:0] p;
		logic [1:0] f;
		ers6(4'h1, 8'h30, 16'hF003);
		i_cpu.wr(16'h0000, 8'h30, 4'h2);
		i_cpu.rd(16'h0000, 4'h1, p);
		chk(p & 8'h88, 8'h00);
		i_cpu.rd(16'h0000, 4'h1, d);
		chk({7'h00, d[6]}, {7'h00, ~p[6]});
		chk({7'h00, ready_busy_pin}, 8'h00);
		watch(16'h0000, 4'h1, f);
		chk({6'h00, f}, 8'h01);
		rdchk(16'h0003, 4'h1, 8'hFF);
		rdchk(16'h0005, 4'h2, 8'hFF);
	endtask
	task automatic t_prog();
		logic [7:0] d;
		i_cpu.prog(16'h0003, 8'hDA, 4'h1);
		i_cpu.rd(16'h0003, 4'h1, d);
		chk({7'h00, d[7]}, 8'h00);
		i_cpu.poll(16'h0003, 4'h1, d);
		chk(d, 8'hDA);
		i_cpu.prog(16'h0003, 8'h5A, 4'h1);
		i_cpu.rd(16'h0003, 4'h1, d);
		chk(d & 8'hA0, 8'h80);
		i_cpu.poll(16'h0003, 4'h1, d);
		chk(d, 8'h5A);
		chk({7'h00, ready_busy_pin}, 8'h01);
	endtask
	task automatic t_fail();
		logic [7:0] d;
		i_cpu.prog(16'h0003, 8'hFF, 4'h1);
		repeat (40) @(posedge sys_clk);
		chk({7'h00, error_flag}, 8'h01);
		i_cpu.rd(16'h0003, 4'h1, d);
		chk({7'h00, d[5]}, 8'h01);
		i_cpu.wr(16'h0555, 8'hAA, 4'h1);
		chk({7'h00, error_flag}, 8'h01);
		i_cpu.wr(16'h0000, 8'hF0, 4'h1);
		@(posedge sys_clk);
		chk({7'h00, error_flag}, 8'h00);
		cell_fault <= 1'h1;
		i_cpu.prog(16'h0004, 8'h00, 4'h1);
		repeat (40) @(posedge sys_clk);
		chk({7'h00, error_flag}, 8'h01);
		cell_fault <= 1'h0;
		i_cpu.wr(16'h0000, 8'hF0, 4'h1);
		@(posedge sys_clk);
		chk({7'h00, error_flag}, 8'h00);
	endtask
	task automatic t_prot();
		logic [7:0] d;
		logic [1:0] f;
		i_cpu.prog(16'h0005, 8'h00, 4'h2);
		i_cpu.poll(16'h0005, 4'h2, d);
		@(posedge sys_clk);
		sector_protect <= 4'h2;
		i_cpu.prog(16'h0006, 8'h11, 4'h2);
		chk({7'h00, ready_busy_pin}, 8'h01);
		rdchk(16'h0006, 4'h2, 8'hFF);
		ers6(4'h2, 8'h30, 16'h0000);
		watch(16'h0005, 4'h2, f);
		chk({7'h00, f[1]}, 8'h01);
		rdchk(16'h0005, 4'h2, 8'h00);
		@(posedge sys_clk);
		sector_protect <= 4'h0;
	endtask
	task automatic t_bypass();
		logic [7:0] d;
		i_cpu.unlock(4'h1);
		i_cpu.wr(16'h0555, 8'h20, 4'h1);
		i_cpu.wr(16'h0123, 8'hA0, 4'h1);
		i_cpu.wr(16'h0007, 8'h3C, 4'h1);
		i_cpu.poll(16'h0007, 4'h1, d);
		chk(d, 8'h3C);
		i_cpu.wr(16'h0FFF, 8'hA0, 4'h1);
		i_cpu.wr(16'h0008, 8'h81, 4'h1);
		i_cpu.poll(16'h0008, 4'h1, d);
		chk(d, 8'h81);
		i_cpu.wr(16'h0000, 8'h90, 4'h1);
		i_cpu.wr(16'h0000, 8'h00, 4'h1);
		i_cpu.wr(16'h0000, 8'hA0, 4'h1);
		i_cpu.wr(16'h0007, 8'h00, 4'h1);
		rdchk(16'h0007, 4'h1, 8'h3C);
	endtask
	task automatic t_refuse();
		i_cpu.prog(16'h0009, 8'h00, 4'h0);
		chk({7'h00, ready_busy_pin}, 8'h01);
		rdchk(16'h0009, 4'h1, 8'hFF);
		i_cpu.unlock(4'h1);
		i_cpu.wr(16'h0555, 8'h77, 4'h1);
		i_cpu.wr(16'h0009, 8'h00, 4'h1);
		rdchk(16'h0009, 4'h1, 8'hFF);
		i_cpu.wr(16'h0555, 8'hAA, 4'h1);
		repeat (900) @(posedge sys_clk);
		i_cpu.wr(16'h0AAA, 8'h55, 4'h1);
		i_cpu.wr(16'h0555, 8'hA0, 4'h1);
		i_cpu.wr(16'h0009, 8'h00, 4'h1);
		rdchk(16'h0009, 4'h1, 8'hFF);
		ers6(4'h1, 8'h30, 16'h0000);
		i_cpu.wr(16'h0000, 8'hF0, 4'h1);
		rdchk(16'h0003, 4'h1, 8'h5A);
		chk({7'h00, ready_busy_pin}, 8'h01);
	endtask
	task automatic t_bulk();
		logic [7:0] d;
		i_cpu.pace = 3;
		ers6(4'h8, 8'h10, 16'h0555);
		i_cpu.poll(16'h0003, 4'h1, d);
		chk(d, 8'hFF);
		rdchk(16'h0005, 4'h2, 8'hFF);
		i_cpu.pace = 0;
	endtask
	initial begin
		#5_000_000;
		n_fail++;
		tally_and_finish();
	end
	initial begin
		repeat (4) @(posedge sys_clk);
		rst <= 1'h0;
		@(posedge sys_clk);
		t_reset();
		t_erase();
		t_prog();
		t_fail();
		t_prot();
		t_bypass();
		t_refuse();
		t_bulk();
		tally_and_finish();
	end
endmodule
